// ===== logic/can_nmt_sync_config.sv
// bus mode attribute, sync handling and network startup of a field bus node
//
// Overview of operation
// - attribute bit 1 set: accept incoming hardware sync; clear: ignore it
// - attribute bit 2 set with bit 1 set: watch hardware sync while operational, flag error when lost
// - attribute bit 3 set: send hardware sync cycle; clear: send nothing
// - bit 4 clear: master checks all configured slaves present, error if missing
// - bit 4 set: master skips absent slaves without error
// - bit 5 clear: synchronous messages follow sync object with identifier 80 hex
// - bit 5 set: synchronous messages follow each hardware sync signal
// - bit 6 clear: non-bus errors keep bus running, clear causes no reinit
// - bit 6 set: every error clear reinitialises the bus
// - bit 9 clear: slave waits 60 seconds for master, then error
// - bit 9 set: slave waits forever for master, no timeout error
// - bit 11 clear: network of several slaves and exactly one master
// - bit 11 set: start as slave without master, go straight to pre-operational
// - master waits bits 15:12 seconds before initialising slaves
// - during init the master detects only pre-operational stations
// - each slave enters pre-operational by itself after own init
// - after startup delay the master commands slaves operational
// - role word bit 1: clear is slave, set is network master
// - address 1 reserved for master; slaves use 2 to 127
`timescale 1ns/1ps
module can_nmt_sync_config
  import can_nmt_pkg::*;
#(
  parameter int NODES = 8,
  parameter int CYCLES_PER_SEC = CYCLES_PER_TICK,
  parameter int SYNC_PERIOD = SYNC_PERIOD_CYC,
  parameter int SYNC_LOSS = SYNC_LOSS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // hardware sync pin
  input wire logic hwSyncIn,
  output logic hwSyncOut,
  // can core side
  input wire logic localInitDone,
  input wire logic syncObjValid,
  input wire logic [10:0] syncObjId,
  input wire logic opCmdRx,
  input wire logic [NODES-1:0] nodePreop,
  // network management and sync results
  output logic syncMsgTx,
  output logic nmtStartPulse,
  output logic [NODES-1:0] nmtStartMask,
  output logic busRunning,
  output logic errorOut
);
  generate
    if (NODES < 1 || NODES > 32) begin : g_chk_nodes
      $error("can_nmt_sync_config: NODES must be 1 to 32");
    end
    if (SYNC_PERIOD < 2 || SYNC_LOSS <= SYNC_PERIOD) begin : g_chk_sync
      $error("can_nmt_sync_config: bad sync timing");
    end
  endgenerate

  // registers
  logic [15:0] attr_r;
  logic roleMaster_r;
  logic [6:0] stationAddr_r;
  logic [NODES-1:0] cfgNodes_r;
  logic errClear_r;
  logic nonBusErr_r;
  node_state_t state_r;
  logic syncLost_r;
  logic nodeMissing_r;
  logic slaveTimeout_r;
  logic addrError_r;
  logic waitReq_r;
  logic [31:0] readData_r;

  // attribute decode
  logic rxSyncEn;
  logic chkSyncEn;
  logic txSyncEn;
  logic skipMissing;
  logic hwSyncMsg;
  logic reinitOnClr;
  logic noTimeout;
  logic noMaster;
  logic [3:0] startDelay;
  logic actMaster;

  assign rxSyncEn = attr_r[ATTR_RX_SYNC];
  assign chkSyncEn = attr_r[ATTR_CHK_SYNC];
  assign txSyncEn = attr_r[ATTR_TX_SYNC];
  assign skipMissing = attr_r[ATTR_SKIP_MISSING];
  assign hwSyncMsg = attr_r[ATTR_HW_SYNC_MSG];
  assign reinitOnClr = attr_r[ATTR_REINIT_CLR];
  assign noTimeout = attr_r[ATTR_NO_TIMEOUT];
  assign noMaster = attr_r[ATTR_NO_MASTER];
  assign startDelay = attr_r[ATTR_DELAY_LSB +: 4];
  assign actMaster = roleMaster_r && !noMaster;

  function automatic logic addr_ok(input logic master, input logic [6:0] a);
    if (master) begin
      addr_ok = (a == ADDR_MASTER);
    end else begin
      addr_ok = (a >= ADDR_SLAVE_MIN) && (a <= ADDR_SLAVE_MAX);
    end
  endfunction : addr_ok

  // bus access
  logic busReq;
  logic wrTake;
  assign busReq = (read || write) && waitReq_r;
  assign wrTake = write && !waitReq_r;

  always_ff @(posedge mclk) begin
    if (reset || !waitReq_r) begin
      waitReq_r <= 1'b1;
    end else if (busReq) begin
      waitReq_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      readData_r <= 32'h0;
    end else if (busReq && read) begin
      case (address)
        OFS_ATTR: readData_r <= {16'h0, attr_r};
        OFS_ROLE: readData_r <= {17'h0, stationAddr_r, 6'h0, roleMaster_r, 1'b0};
        OFS_CTRL: readData_r <= 32'h0;
        OFS_STAT: readData_r <= {24'h0, addrError_r, slaveTimeout_r, nodeMissing_r,
                                 syncLost_r, busRunning, 3'(state_r)};
        OFS_NODES: readData_r <= 32'(cfgNodes_r);
        default: readData_r <= 32'h0;
      endcase
    end
  end

  // writable configuration
  always_ff @(posedge mclk) begin
    if (reset) begin
      attr_r <= ATTR_RESET;
      roleMaster_r <= 1'b0;
      stationAddr_r <= ADDR_RESET;
      cfgNodes_r <= '0;
    end else if (wrTake) begin
      if (address == OFS_ATTR) begin
        attr_r <= writedata[15:0];
      end
      if (address == OFS_ROLE) begin
        roleMaster_r <= writedata[ROLE_MASTER];
        stationAddr_r <= writedata[ROLE_ADDR_LSB +: 7];
      end
      if (address == OFS_NODES) begin
        cfgNodes_r <= writedata[NODES-1:0];
      end
    end
  end

  // self-clearing commands
  always_ff @(posedge mclk) begin
    if (reset) begin
      errClear_r <= 1'b0;
      nonBusErr_r <= 1'b0;
    end else begin
      errClear_r <= wrTake && (address == OFS_CTRL) && writedata[CTRL_ERR_CLR];
      nonBusErr_r <= wrTake && (address == OFS_CTRL) && writedata[CTRL_NONBUS_ERR];
    end
  end

  // hardware sync input
  logic syncMeta_r;
  logic syncIn_r;
  logic syncPrev_r;
  logic syncRise;
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncMeta_r <= 1'b0;
      syncIn_r <= 1'b0;
      syncPrev_r <= 1'b0;
    end else begin
      syncMeta_r <= hwSyncIn;
      syncIn_r <= syncMeta_r;
      syncPrev_r <= syncIn_r;
    end
  end
  assign syncRise = rxSyncEn && syncIn_r && !syncPrev_r;

  // hardware sync sender
  logic [31:0] syncDiv_r;
  logic syncOutEvt;
  assign syncOutEvt = txSyncEn && (syncDiv_r == 32'(SYNC_PERIOD - 1));
  always_ff @(posedge mclk) begin
    if (reset || !txSyncEn || syncOutEvt) begin
      syncDiv_r <= 32'h0;
    end else begin
      syncDiv_r <= syncDiv_r + 32'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      hwSyncOut <= 1'b0;
    end else begin
      hwSyncOut <= syncOutEvt;
    end
  end

  // sync loss watchdog
  logic [31:0] syncAge_r;
  logic syncWatch;
  assign syncWatch = chkSyncEn && rxSyncEn && (state_r == stOperational);
  always_ff @(posedge mclk) begin
    if (reset || !syncWatch || syncRise) begin
      syncAge_r <= 32'h0;
    end else if (syncAge_r != 32'(SYNC_LOSS)) begin
      syncAge_r <= syncAge_r + 32'h1;
    end
  end

  // synchronous message trigger
  logic hwEvt;
  assign hwEvt = syncRise || syncOutEvt;
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncMsgTx <= 1'b0;
    end else if (state_r != stOperational) begin
      syncMsgTx <= 1'b0;
    end else if (hwSyncMsg) begin
      syncMsgTx <= hwEvt;
    end else begin
      syncMsgTx <= syncObjValid && (syncObjId == SYNC_COB_ID);
    end
  end

  // seconds timebase
  sec_tick_if secIf ();
  seconds_timebase #(
    .CYCLES(CYCLES_PER_SEC)
  ) u_timebase (
    .mclk(mclk),
    .reset(reset),
    .tb(secIf.timer)
  );

  // node state machine
  logic [5:0] secCount_r;
  logic restartBus;
  logic stateChange;
  node_state_t state_nxt;
  logic [NODES-1:0] missing;
  assign restartBus = errClear_r && reinitOnClr;
  assign missing = cfgNodes_r & ~nodePreop;
  assign stateChange = (state_nxt != state_r) || restartBus;
  assign secIf.restart = stateChange;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stBoot: begin
        if (localInitDone && addr_ok(actMaster, stationAddr_r)) begin
          state_nxt = actMaster ? stMasterDelay : stPreop;
        end
      end
      stMasterDelay: begin
        if (secCount_r[3:0] >= startDelay) begin
          state_nxt = stScan;
        end
      end
      stScan: begin
        if (missing != '0 && !skipMissing) begin
          state_nxt = stFault;
        end else begin
          state_nxt = stOperational;
        end
      end
      stPreop: begin
        if (opCmdRx && !noMaster) begin
          state_nxt = stOperational;
        end else if (!noMaster && !noTimeout && secCount_r >= SLAVE_WAIT_S) begin
          state_nxt = stFault;
        end
      end
      stOperational: begin
        if (syncAge_r == 32'(SYNC_LOSS)) begin
          state_nxt = stFault;
        end
      end
      stFault: begin
        if (errClear_r) begin
          state_nxt = stBoot;
        end
      end
      default: state_nxt = stBoot;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset || restartBus) begin
      state_r <= stBoot;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || stateChange) begin
      secCount_r <= 6'h0;
    end else if (secIf.tick && secCount_r != 6'h3f) begin
      secCount_r <= secCount_r + 6'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      nmtStartPulse <= 1'b0;
      nmtStartMask <= '0;
    end else if (state_r == stScan && state_nxt == stOperational) begin
      nmtStartPulse <= 1'b1;
      nmtStartMask <= cfgNodes_r & nodePreop;
    end else begin
      nmtStartPulse <= 1'b0;
    end
  end

  // sticky errors, set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncLost_r <= 1'b0;
      nodeMissing_r <= 1'b0;
      slaveTimeout_r <= 1'b0;
      addrError_r <= 1'b0;
    end else begin
      if (syncWatch && syncAge_r == 32'(SYNC_LOSS)) begin
        syncLost_r <= 1'b1;
      end else if (errClear_r) begin
        syncLost_r <= 1'b0;
      end
      if (state_r == stScan && missing != '0 && !skipMissing) begin
        nodeMissing_r <= 1'b1;
      end else if (errClear_r) begin
        nodeMissing_r <= 1'b0;
      end
      if (state_r == stPreop && state_nxt == stFault) begin
        slaveTimeout_r <= 1'b1;
      end else if (errClear_r) begin
        slaveTimeout_r <= 1'b0;
      end
      if (state_r == stBoot && localInitDone && !addr_ok(actMaster, stationAddr_r)) begin
        addrError_r <= 1'b1;
      end else if (errClear_r) begin
        addrError_r <= 1'b0;
      end
    end
  end

  // outputs
  logic nonBusErrSeen_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      nonBusErrSeen_r <= 1'b0;
    end else if (nonBusErr_r) begin
      nonBusErrSeen_r <= 1'b1;
    end else if (errClear_r) begin
      nonBusErrSeen_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busRunning <= 1'b0;
      errorOut <= 1'b0;
    end else begin
      busRunning <= !restartBus && ((state_nxt == stPreop) || (state_nxt == stOperational)
                    || (state_nxt == stMasterDelay) || (state_nxt == stScan));
      errorOut <= syncLost_r || nodeMissing_r || slaveTimeout_r || addrError_r
                  || nonBusErrSeen_r;
    end
  end

  assign readdata = readData_r;
  assign waitrequest = waitReq_r;
endmodule : can_nmt_sync_config

// ===== include/can_nmt_pkg.sv
// constants for the bus mode attribute and network management block
package can_nmt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ATTR = 8'h00;
  localparam logic [7:0] OFS_ROLE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_NODES = 8'h10;
  // attribute word fields
  localparam int ATTR_RX_SYNC = 1;
  localparam int ATTR_CHK_SYNC = 2;
  localparam int ATTR_TX_SYNC = 3;
  localparam int ATTR_SKIP_MISSING = 4;
  localparam int ATTR_HW_SYNC_MSG = 5;
  localparam int ATTR_REINIT_CLR = 6;
  localparam int ATTR_NO_TIMEOUT = 9;
  localparam int ATTR_NO_MASTER = 11;
  localparam int ATTR_DELAY_LSB = 12;
  localparam logic [15:0] ATTR_RESET = 16'h0000;
  // role word fields
  localparam int ROLE_MASTER = 1;
  localparam int ROLE_ADDR_LSB = 8;
  localparam logic [6:0] ADDR_RESET = 7'h02;
  localparam logic [6:0] ADDR_MASTER = 7'h01;
  localparam logic [6:0] ADDR_SLAVE_MIN = 7'h02;
  localparam logic [6:0] ADDR_SLAVE_MAX = 7'h7f;
  // control word fields
  localparam int CTRL_ERR_CLR = 0;
  localparam int CTRL_NONBUS_ERR = 1;
  // network sync object identifier
  localparam logic [10:0] SYNC_COB_ID = 11'h080;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int CYCLES_PER_TICK = CLK_HZ * TICK_PERIOD_S;
  localparam logic [5:0] SLAVE_WAIT_S = 6'h3c;
  localparam int SYNC_PERIOD_CYC = 100_000;
  localparam int SYNC_LOSS_CYC = 300_000;
  // node states
  typedef enum logic [2:0] {
    stBoot, stMasterDelay, stScan, stPreop, stOperational, stFault
  } node_state_t;
endpackage : can_nmt_pkg

// ===== include/sec_tick_if.sv
// seconds timebase link between control logic and divider
`timescale 1ns/1ps
interface sec_tick_if;
  logic restart;
  logic tick;
  modport ctrl (output restart, input tick);
  modport timer (input restart, output tick);
endinterface : sec_tick_if

// ===== logic/seconds_timebase.sv
// one-cycle enable pulse once per second
`timescale 1ns/1ps
module seconds_timebase #(
  parameter int CYCLES = 100_000_000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // tick link
  sec_tick_if.timer tb
);
  generate
    if (CYCLES < 2) begin : g_chk
      $error("seconds_timebase: CYCLES too small");
    end
  endgenerate

  logic [31:0] count_r;
  logic tick_r;

  always_ff @(posedge mclk) begin
    if (reset || tb.restart) begin
      count_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (count_r == 32'(CYCLES - 1)) begin
      count_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      count_r <= count_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  assign tb.tick = tick_r;
endmodule : seconds_timebase

// ===== testbench/can_nmt_sync_config_chk.sv
// port assertions for the bus mode block
`timescale 1ns/1ps
module can_nmt_sync_config_chk
  import can_nmt_pkg::*;
#(
  parameter int NODES = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // avalon-mm
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // sync and can side
  input wire logic hwSyncOut,
  input wire logic syncObjValid,
  input wire logic [10:0] syncObjId,
  input wire logic [NODES-1:0] nodePreop,
  // results
  input wire logic syncMsgTx,
  input wire logic nmtStartPulse,
  input wire logic [NODES-1:0] nmtStartMask,
  input wire logic busRunning,
  input wire logic errorOut
);
  logic [15:0] attr_r;
  logic objHit;
  logic ctrlWr;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  assign objHit = syncObjValid && syncObjId == SYNC_COB_ID;
  assign ctrlWr = write && !waitrequest && address == OFS_CTRL;
  // copy of the attribute word
  always_ff @(posedge mclk) begin
    if (reset) begin
      attr_r <= ATTR_RESET;
    end else if (write && !waitrequest && address == OFS_ATTR) begin
      attr_r <= writedata[15:0];
    end
  end
  sequence taken_s;
    (read || write) && waitrequest;
  endsequence
  sequence done_s;
    read && !waitrequest;
  endsequence
  ans_next_a: assert property (taken_s |=> !waitrequest)
    else $error("no answer one cycle after request");
  wait_one_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  unmapped_zero_a: assert property (done_s ##0 (address > OFS_NODES || address == OFS_CTRL)
    |-> readdata == 32'h0) else $error("unmapped or control read not zero");
  sync_off_a: assert property (!attr_r[3] && !$past(attr_r[3]) |-> !hwSyncOut)
    else $error("sync sent while sender off");
  nmt_pulse_a: assert property (nmtStartPulse |=> !nmtStartPulse)
    else $error("start command longer than one cycle");
  nmt_preop_a: assert property (nmtStartPulse |-> (nmtStartMask & ~$past(nodePreop)) == '0)
    else $error("start sent to station not pre-operational");
  sync_obj_a: assert property ($rose(syncMsgTx) && !attr_r[5] && !$past(attr_r[5])
    |-> $past(objHit)) else $error("sync messages without sync object");
  err_set_a: assert property (ctrlWr && writedata[1] |-> ##3 errorOut)
    else $error("non-bus error not flagged");
  nonbus_run_a: assert property (ctrlWr && writedata[1] && !writedata[0] && busRunning
    |=> busRunning [*2]) else $error("bus stopped on non-bus error");
  clear_reinit_a: assert property (ctrlWr && writedata[0] && attr_r[6] && busRunning
    |-> ##[1:3] !busRunning) else $error("error clear did not reinitialise");
endmodule : can_nmt_sync_config_chk
bind can_nmt_sync_config can_nmt_sync_config_chk #(.NODES(NODES)) chkI (
  .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .hwSyncOut(hwSyncOut), .syncObjValid(syncObjValid), .syncObjId(syncObjId),
  .nodePreop(nodePreop), .syncMsgTx(syncMsgTx), .nmtStartPulse(nmtStartPulse),
  .nmtStartMask(nmtStartMask), .busRunning(busRunning), .errorOut(errorOut));

// ===== testbench/can_station_model.sv
// slave stations on the far side of the field bus
`timescale 1ns/1ps
module can_station_model #(
  parameter int NODES = 8,
  parameter int INIT_CYC = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // stations fitted
  input wire logic [NODES-1:0] present,
  // network management
  input wire logic nmtStartPulse,
  input wire logic [NODES-1:0] nmtStartMask,
  output logic [NODES-1:0] nodePreop
);
  int cnt;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt <= 0;
      nodePreop <= '0;
    end else if (cnt <= INIT_CYC) begin
      cnt <= cnt + 1;
      nodePreop <= (cnt == INIT_CYC) ? present : '0;
    end else if (nmtStartPulse) begin
      nodePreop <= nodePreop & ~nmtStartMask;
    end
  end
endmodule : can_station_model

// ===== testbench/tb_can_nmt_sync_config.sv
// self-checking bench for the bus mode block
`timescale 1ns/1ps
module tb_can_nmt_sync_config;
  import can_nmt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic mclk, reset, read, write, waitrequest, hwSyncIn, hwSyncOut, localInitDone, s;
  logic syncObjValid, opCmdRx, syncMsgTx, nmtStartPulse, busRunning, errorOut;
  logic [7:0] address, present, nodePreop, nmtStartMask;
  logic [10:0] syncObjId;
  logic [31:0] writedata, readdata, q;
  int error_cnt = 0, n_compared = 0, cyc = 0, n;
  row_t rows [6] = '{'{8'h00, 32'h581, 32'h581}, '{8'h00, 32'hffffffff, 32'hffff},
    '{8'h04, 32'h102, 32'h102}, '{8'h08, 32'h0, 32'h0}, '{8'h40, 32'hffffffff, 32'h0},
    '{8'h10, 32'hff, 32'hff}};
  can_nmt_sync_config #(.CYCLES_PER_SEC(20), .SYNC_PERIOD(8), .SYNC_LOSS(30)) dut (
    .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hwSyncIn(hwSyncIn), .hwSyncOut(hwSyncOut), .localInitDone(localInitDone),
    .syncObjValid(syncObjValid), .syncObjId(syncObjId), .opCmdRx(opCmdRx),
    .nodePreop(nodePreop), .syncMsgTx(syncMsgTx), .nmtStartPulse(nmtStartPulse),
    .nmtStartMask(nmtStartMask), .busRunning(busRunning), .errorOut(errorOut));
  // stations ready before master delay ends
  can_station_model peer (.mclk(mclk), .reset(reset),
    .present(present), .nmtStartPulse(nmtStartPulse), .nmtStartMask(nmtStartMask),
    .nodePreop(nodePreop));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask : acc
  task automatic rst(input logic [7:0] p);
    reset <= 1'b1;
    localInitDone <= 1'b0;
    present <= p;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask : rst
  task automatic master(input logic [31:0] nodes, input logic [31:0] attr);
    acc(1'b1, OFS_NODES, nodes);
    acc(1'b1, OFS_ROLE, 32'h102);
    acc(1'b1, OFS_ATTR, attr);
    localInitDone <= 1'b1;
    n = 0;
    while (nmtStartPulse !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
  endtask : master
  task automatic watch();
    s = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      if (syncMsgTx === 1'b1) s = 1'b1;
    end
  endtask : watch
  task automatic slave(input logic [31:0] attr, input logic [31:0] role);
    rst(8'h00);
    acc(1'b1, OFS_ATTR, attr);
    acc(1'b1, OFS_ROLE, role);
    localInitDone <= 1'b1;
    repeat (3) @(posedge mclk);
    opCmdRx <= 1'b1;
    @(posedge mclk);
    opCmdRx <= 1'b0;
    acc(1'b0, OFS_STAT, 32'h0);
  endtask : slave
  initial begin
    {reset, read, write, hwSyncIn, localInitDone, syncObjValid, opCmdRx} = 7'h40;
    {address, present, syncObjId, writedata} = '0;
    rst(8'h00);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d);
      acc(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    $display("register rows done");
    rst(8'h00);
    acc(1'b0, OFS_ATTR, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, OFS_ROLE, 32'h0);
    chk(q, 32'h200);
    $display("reset values done");
    rst(8'h03);
    master(32'h03, 32'h2008);
    chk(32'(n >= 39 && n <= 46), 32'h1);
    chk(32'(nmtStartMask), 32'h3);
    chk(32'(errorOut), 32'h0);
    n = 0;
    repeat (32) begin
      @(posedge mclk);
      n += int'(hwSyncOut === 1'b1);
    end
    chk(32'(n), 32'h4);
    $display("master start done");
    for (int k = 0; k < 2; k++) begin
      rst(8'h03);
      master(32'h07, k ? 32'h1010 : 32'h1000);
      if (k) chk(32'(nmtStartMask), 32'h3);
      repeat (2) @(posedge mclk);
      chk(32'(errorOut), 32'(k == 0));
    end
    $display("missing node done");
    for (int k = 0; k < 2; k++) begin
      rst(8'h00);
      acc(1'b1, OFS_ATTR, k ? 32'h200 : 32'h0);
      localInitDone <= 1'b1;
      repeat (1150) @(posedge mclk);
      chk(32'(errorOut), 32'h0);
      repeat (150) @(posedge mclk);
      chk(32'(errorOut), 32'(k == 0));
    end
    $display("slave wait done");
    slave(32'h800, 32'h200);
    chk(q & 32'hf, 32'hb);
    slave(32'h0, 32'h100);
    chk(q & 32'h87, 32'h80);
    slave(32'h0, 32'h200);
    chk(q & 32'hf, 32'hc);
    for (int k = 0; k < 2; k++) begin
      syncObjValid <= 1'b1;
      syncObjId <= k ? SYNC_COB_ID : 11'h081;
      @(posedge mclk);
      syncObjValid <= 1'b0;
      watch();
      chk(32'(s), 32'(k));
    end
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, OFS_ATTR, k ? 32'h22 : 32'h20);
      hwSyncIn <= 1'b1;
      repeat (3) @(posedge mclk);
      hwSyncIn <= 1'b0;
      watch();
      chk(32'(s), 32'(k));
    end
    $display("sync trigger done");
    acc(1'b1, OFS_CTRL, 32'h2);
    repeat (2) @(posedge mclk);
    chk(32'(errorOut), 32'h1);
    acc(1'b1, OFS_CTRL, 32'h1);
    acc(1'b0, OFS_STAT, 32'h0);
    chk(q & 32'hf, 32'hc);
    acc(1'b1, OFS_ATTR, 32'h40);
    acc(1'b1, OFS_CTRL, 32'h1);
    @(posedge mclk);
    acc(1'b0, OFS_STAT, 32'h0);
    chk(q & 32'hf, 32'hb);
    $display("error clear done");
    opCmdRx <= 1'b1;
    @(posedge mclk);
    opCmdRx <= 1'b0;
    acc(1'b1, OFS_ATTR, 32'h6);
    repeat (40) @(posedge mclk);
    acc(1'b0, OFS_STAT, 32'h0);
    chk(q & 32'h1f, 32'h15);
    chk(32'(errorOut), 32'h1);
    $display("sync loss done");
    close_out();
  end
endmodule : tb_can_nmt_sync_config
